// File: design/output_divider_digital_delay.sv
// Output divider bank with dynamic digital delay, reached over APB.
// Assumes pclk is the distribution path clock seen in half periods: one pclk
// cycle is one half period, so half steps of delay are whole pclk cycles.
//
// What this block does
// (RQ1) Retime outputs at run time, minimal interruption
// (RQ2) One step is half a distribution period
// (RQ3) Qualifying output chosen by select setting
// (RQ4) Same output requalified shifts again each sync
// (RQ5) Software sets half step before sync
// (RQ6) Delay equals count minus half step/2
// (RQ7) Software programs zero-offset delay from formula
// (RQ8) Zero offset depends on qualifying divide only
// (RQ9) Half step change moves one time step
// (RQ10) Effective delay never below four and half
// (RQ11) Larger equivalent delay holds output longer
//
// Chosen here: the placing of the registers and register access over APB.
`include "ddly_params.svh"
`timescale 1ns/100ps
`default_nettype none

module output_divider_digital_delay #(
    parameter int NUM_PAIRS = 2,   // Output pairs served
    parameter int DIV_W     = 11,  // Divide value width
    parameter int DLY_W     = 10   // Delay count width
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output var  logic [31:0]          prdata,
    output logic                      pready,
    output var  logic                 pslverr,
    // Synchronisation pin, asynchronous, rising edge
    input  wire logic                 sync_in,
    // Divided clock outputs
    output var  logic [NUM_PAIRS-1:0] clk_out
);
    import ddly_pkg::*;

    localparam int SEL_W = (NUM_PAIRS > 1) ? $clog2(NUM_PAIRS) : 1;
    localparam int HW    = DLY_W + 2;  // Width of a delay in half periods
    localparam int CW    = DLY_W + 3;  // Width of the hold counter

    // Elaboration check: status and enable words hold 16 pairs at most
    if (NUM_PAIRS < 1 || NUM_PAIRS > 16 || DIV_W > 16 || DLY_W > 12 || DLY_W < 4) begin : g_bad_params
        $error("output_divider_digital_delay: unsupported parameters");
    end

    // Configuration registers
    logic [SEL_W-1:0]     qualifying_output_select;        // Reference pair
    logic [NUM_PAIRS-1:0] sync_enable;                     // Pairs resynchronised on sync
    logic [DIV_W-1:0]     output_pair_divide_value [NUM_PAIRS];
    logic [DLY_W-1:0]     output_pair_delay_count  [NUM_PAIRS];
    logic                 output_pair_half_step    [NUM_PAIRS];
    logic                 soft_sync;                       // One-cycle software sync

    // Per pair state
    pair_state_e          pair_state [NUM_PAIRS];
    logic [DIV_W-1:0]     div_count  [NUM_PAIRS];          // Half periods in current level
    logic [CW-1:0]        hold_count [NUM_PAIRS];          // Half periods left in hold
    logic [HW-1:0]        armed_half [NUM_PAIRS];          // Delay captured at sync

    // Sync pin synchroniser and edge detect
    logic                 sync_meta;
    logic                 sync_stable;
    logic                 sync_last;
    logic                 sync_event;
    logic                 qual_last;
    logic                 qual_fall;

    // Effective delay in half periods, clamped to the smallest supported
    function automatic logic [HW-1:0] delay_half(input logic [DLY_W-1:0] cnt, input logic hs);
        logic [HW-1:0] d;
        d = {1'b0, cnt, 1'b0} - {{(HW-1){1'b0}}, hs};      // RQ6 RQ2
        if (d < HW'(`MIN_DELAY_HALF)) begin                // RQ10
            d = HW'(`MIN_DELAY_HALF);
        end
        return d;
    endfunction

    // Pair index of an address, or NUM_PAIRS when it names no pair
    function automatic int pair_index(input logic [11:0] addr);
        int idx;
        idx = NUM_PAIRS;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (addr == 12'(`REG_PAIR_BASE + i * `REG_PAIR_STRIDE)) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    // Divide value of zero behaves as one
    function automatic logic [DIV_W-1:0] div_eff(input logic [DIV_W-1:0] v);
        return (v == '0) ? DIV_W'(1) : v;
    endfunction

    // Zero wait states; data is staged in the setup cycle
    assign pready = 1'b1;

    // Two flops before any logic looks at the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta   <= 1'b0;
            sync_stable <= 1'b0;
            sync_last   <= 1'b0;
        end else begin
            sync_meta   <= sync_in;
            sync_stable <= sync_meta;
            sync_last   <= sync_stable;
        end
    end

    assign sync_event = (sync_stable & ~sync_last) | soft_sync;

    // Falling edge of the selected qualifying output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qual_last <= 1'b0;
        end else begin
            qual_last <= clk_out[qualifying_output_select];  // RQ3
        end
    end

    assign qual_fall = qual_last & ~clk_out[qualifying_output_select];  // RQ3

    // Register writes, taken in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qualifying_output_select <= '0;
            sync_enable              <= NUM_PAIRS'(`RST_SYNC_ENABLE);
            soft_sync                <= 1'b0;
            for (int i = 0; i < NUM_PAIRS; i++) begin
                output_pair_divide_value[i] <= DIV_W'(`RST_DIVIDE);
                output_pair_delay_count[i]  <= DLY_W'(`RST_DELAY);
                output_pair_half_step[i]    <= `RST_HALF_STEP;
            end
        end else begin
            soft_sync <= 1'b0;
            if (psel && penable && pwrite) begin
                if (paddr == `REG_CONTROL) begin
                    qualifying_output_select <= pwdata[`CTRL_SEL_LSB +: SEL_W];
                    soft_sync                <= pwdata[`CTRL_SYNC_BIT];
                end else if (paddr == `REG_SYNC_ENABLE) begin
                    sync_enable <= pwdata[NUM_PAIRS-1:0];
                end else if (pair_index(paddr) < NUM_PAIRS) begin
                    // Half step may change while armed: value at sync is kept
                    output_pair_divide_value[pair_index(paddr)] <= pwdata[`PAIR_DIV_LSB +: DIV_W];
                    output_pair_delay_count[pair_index(paddr)]  <= pwdata[`PAIR_DLY_LSB +: DLY_W];
                    output_pair_half_step[pair_index(paddr)]    <= pwdata[`PAIR_HS_BIT];
                end
            end
        end
    end

    // Read data and error staged in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == `REG_CONTROL) begin
                prdata[`CTRL_SEL_LSB +: SEL_W] <= qualifying_output_select;
            end else if (paddr == `REG_SYNC_ENABLE) begin
                prdata[NUM_PAIRS-1:0] <= sync_enable;
            end else if (paddr == `REG_STATUS) begin
                for (int i = 0; i < NUM_PAIRS; i++) begin
                    prdata[`STAT_HOLD_LSB + i]  <= (pair_state[i] != PAIR_RUN);
                    prdata[`STAT_LEVEL_LSB + i] <= clk_out[i];
                end
            end else if (pair_index(paddr) < NUM_PAIRS) begin
                prdata[`PAIR_DIV_LSB +: DIV_W] <= output_pair_divide_value[pair_index(paddr)];
                prdata[`PAIR_DLY_LSB +: DLY_W] <= output_pair_delay_count[pair_index(paddr)];
                prdata[`PAIR_HS_BIT]           <= output_pair_half_step[pair_index(paddr)];
            end else begin
                pslverr <= 1'b1;   // Unmapped address
            end
        end
    end

    // Dividers and the sync sequence of each pair. Disabled pairs run freely,
    // so only the pairs being retimed are interrupted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
                pair_state[i] <= PAIR_RUN;
                div_count[i]  <= '0;
                hold_count[i] <= '0;
                armed_half[i] <= '0;
                clk_out[i]    <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
                // 50% duty divider: each level lasts divide half periods
                if (pair_state[i] != PAIR_HOLD) begin
                    if (div_count[i] >= div_eff(output_pair_divide_value[i]) - DIV_W'(1)) begin
                        div_count[i] <= '0;
                        clk_out[i]   <= ~clk_out[i];
                    end else begin
                        div_count[i] <= div_count[i] + DIV_W'(1);
                    end
                end
                case (pair_state[i])
                    PAIR_RUN: begin
                        // Capture the delay now: later writes do not matter
                        if (sync_event && sync_enable[i]) begin
                            armed_half[i] <= delay_half(output_pair_delay_count[i],
                                                        output_pair_half_step[i]);  // RQ5 RQ6
                            pair_state[i] <= PAIR_ARM;
                        end
                    end
                    PAIR_ARM: begin
                        // Measure from the qualifying falling edge, so the
                        // zero-offset delay needs only its divide value
                        if (qual_fall) begin                                        // RQ8 RQ3
                            hold_count[i] <= CW'(armed_half[i]) + CW'(`ALIGN_LATENCY_HALF) - CW'(1);
                            clk_out[i]    <= 1'b0;
                            div_count[i]  <= '0;
                            pair_state[i] <= PAIR_HOLD;                             // RQ1
                        end
                    end
                    PAIR_HOLD: begin
                        // Longer equivalent delays simply stay low longer
                        if (hold_count[i] <= CW'(1)) begin                          // RQ11 RQ9
                            clk_out[i]    <= 1'b1;
                            div_count[i]  <= '0;
                            pair_state[i] <= PAIR_RUN;                              // RQ4
                        end else begin
                            hold_count[i] <= hold_count[i] - CW'(1);
                        end
                    end
                    default: begin
                        pair_state[i] <= PAIR_RUN;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: design/ddly_params.svh
// Constants of the output divider digital delay block: register map, fields,
// reset values and timing. Definitions only; included by the divider module.
`ifndef DDLY_PARAMS_SVH
`define DDLY_PARAMS_SVH

// Register byte addresses
`define REG_CONTROL          12'h000
`define REG_SYNC_ENABLE      12'h004
`define REG_STATUS           12'h008
`define REG_PAIR_BASE        12'h010
`define REG_PAIR_STRIDE      12'h004

// Control word fields
`define CTRL_SEL_LSB         0
`define CTRL_SYNC_BIT        8

// Pair word fields: divide value, delay count, half step
`define PAIR_DIV_LSB         0
`define PAIR_DLY_LSB         16
`define PAIR_HS_BIT          31

// Status word fields
`define STAT_HOLD_LSB        0
`define STAT_LEVEL_LSB       16

// Reset values
`define RST_DIVIDE           11'h001
`define RST_DELAY            10'h005
`define RST_HALF_STEP        1'b0
`define RST_SYNC_ENABLE      16'hFFFF

// Smallest effective delay, in half distribution periods (4.5 periods)
`define MIN_DELAY_HALF       12'h009
// Fixed hold latency after the qualifying falling edge, in half periods
`define ALIGN_LATENCY_HALF   13'h0017

`endif

// File: design/ddly_pkg.sv
// Types shared by the output divider digital delay block.
// Assumes ddly_params.svh carries the numeric constants.
package ddly_pkg;
    // Life of one output pair around a synchronisation event
    typedef enum logic [1:0] {
        PAIR_RUN,
        PAIR_ARM,
        PAIR_HOLD
    } pair_state_e;
endpackage

// File: tb/ddly_monitor.sv
// Checker for the output divider delay block: APB answers and output reset.
// Assumes one clock domain (pclk) and the block's own port names.
`timescale 1ns/100ps
`default_nettype none
module ddly_monitor #(
    parameter int NUM_PAIRS = 2  // Output pairs served
) (
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Divided outputs
    input wire logic [NUM_PAIRS-1:0] clk_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;  // Address hits a register
    logic rd_acc;  // Read access cycle
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008} ||
                    (paddr >= 12'h010 && paddr < 12'h010 + 12'(4 * NUM_PAIRS) && paddr[1:0] == 2'h0);
    assign rd_acc = psel && penable && !pwrite;
    // Setup cycle followed by its access cycle
    sequence access_s;
        psel && !penable ##1 psel && penable;
    endsequence
    pready_high_a: assert property (pready) else $error("pready low");
    err_unmapped_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no error on hole");
    err_mapped_a: assert property (psel && penable && mapped |-> !pslverr) else $error("error on register");
    hole_zero_a: assert property (rd_acc && !mapped |-> prdata == 32'h0) else $error("hole read not zero");
    sync_reads0_a: assert property (rd_acc && paddr == 12'h000 |-> !prdata[8]) else $error("sync bit reads one");
    status_level_a: assert property (rd_acc && paddr == 12'h008 |-> prdata[17:16] == $past(clk_out[1:0]))
        else $error("status level wrong");
    rdata_stands_a: assert property (access_s ##1 !psel |-> $stable(prdata) && $stable(pslverr))
        else $error("read data moved");
    out_reset_a: assert property ($rose(presetn) |-> clk_out == '0) else $error("output not reset");
endmodule
bind output_divider_digital_delay ddly_monitor #(.NUM_PAIRS(NUM_PAIRS)) mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_out(clk_out));
`default_nettype wire

// File: tb/clock_receiver.sv
// Downstream receiver of two divided clocks: times each restart after a hold.
// Assumes outputs change only at pclk edges.
`timescale 1ns/100ps
`default_nettype none
module clock_receiver #(
    parameter int LONG_LOW = 25  // Low runs longer than this are holds
) (
    input wire logic       pclk,
    input wire logic [1:0] clk_out
);
    int         cyc;           // Edge counter
    logic [1:0] prev = 2'h0;   // Level at previous edge
    int         low_run[2];    // Current low run
    int         last_rise[2];  // Edge of latest rise
    int         lag[2];        // Restart minus other output's latest rise
    int         off_len[2];    // Length of the hold seen
    int         long_cnt[2];   // Holds seen
    // Rises are logged first so a coincident rise of the other clock counts
    always @(posedge pclk) begin
        cyc = cyc + 1;
        for (int i = 0; i < 2; i++)
            if (clk_out[i] && !prev[i]) last_rise[i] = cyc;
        for (int i = 0; i < 2; i++) begin
            if (clk_out[i] && !prev[i] && low_run[i] > LONG_LOW) begin
                lag[i] = cyc - last_rise[1-i];
                off_len[i] = low_run[i];
                long_cnt[i] = long_cnt[i] + 1;
            end
            low_run[i] = clk_out[i] ? 0 : low_run[i] + 1;
        end
        prev = clk_out;
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: programs delays over APB, fires sync, times restarts.
// Assumes pclk is one half period of the distribution clock.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, sync_in, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  clk_out;
    int          fail_count = 0;
    int          comparisons = 0;
    output_divider_digital_delay dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_in(sync_in), .clk_out(clk_out));
    clock_receiver rx (.pclk(pclk), .clk_out(clk_out));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle edge follows so calls never collide
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // Pair word: half step, delay count, divide value
    function automatic logic [31:0] word(input logic h, input logic [9:0] c, input logic [10:0] d);
        return {h, 5'h00, c, 5'h00, d};
    endfunction
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk(r, 32'h0005_0001);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(r, 32'h0000_0003);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk(r & 32'h0000_FFFF, 32'h0);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h00C, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    // Waits until output p ends a hold counted after snap; a hang fails the run
    task automatic wait_restart(input int p, input int snap);
        int n = 0;
        while (rx.long_cnt[p] == snap && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    // Qualifying pair retimed against itself: each event shifts it one step more
    task automatic t_relative();
        logic [31:0] r;
        logic e;
        int lag1;
        int snap;
        wr(12'h010, word(1'b0, 10'h00E, 11'h00A));
        wr(12'h014, word(1'b0, 10'h005, 11'h00A));
        wr(12'h004, 32'h1);
        wr(12'h000, 32'h0);
        snap = rx.long_cnt[0];
        wr(12'h000, 32'h100);
        wait_restart(0, snap);
        lag1 = rx.lag[0];
        snap = rx.long_cnt[0];
        wr(12'h000, 32'h100);
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk(r & 32'h0000_0001, 32'h1);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk(r, 32'h0);
        wait_restart(0, snap);
        chk(32'((rx.lag[0] + 20 - lag1) % 20), 32'h1);
        $display("test relative done");
    endtask
    // Qualifying pair q, the other pair synchronised; lag is phase to q's rise
    task automatic t_align(input int q, input logic [10:0] dq, input logic [10:0] ds, input logic [9:0] c,
                           input logic h, input logic pin, input int lag, input int min_off);
        int snap;
        wr(12'h010 + 12'(4 * q), word(1'b0, 10'h005, dq));
        wr(12'h010 + 12'(4 * (1 - q)), word(h, c, ds));
        wr(12'h004, 32'(2 - q));
        wr(12'h000, 32'(q));
        snap = rx.long_cnt[1-q];
        if (pin) begin
            sync_in <= 1'b1;
            repeat (4) @(posedge pclk);
            sync_in <= 1'b0;
        end else wr(12'h000, 32'h100 | 32'(q));
        // Half step rewritten after the event must not change it
        wr(12'h010 + 12'(4 * (1 - q)), word(1'b0, c, ds));
        wait_restart(1 - q, snap);
        chk(32'(rx.lag[1-q] % (2 * dq)), 32'(lag));
        chk(32'(rx.off_len[1-q] >= min_off), 32'h1);
        $display("test align done, count %0d half %0d", c, h);
    endtask
    initial begin
        {psel, penable, pwrite, sync_in, presetn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_align(0, 10, 20, 14, 1'b1, 1'b0, 0, 49);
        t_align(0, 10, 5, 14, 1'b1, 1'b0, 0, 49);
        t_align(0, 10, 20, 14, 1'b1, 1'b1, 0, 49);
        t_align(0, 10, 20, 14, 1'b0, 1'b0, 1, 50);
        t_align(0, 10, 20, 2, 1'b0, 1'b0, 2, 31);
        t_align(0, 10, 20, 15, 1'b1, 1'b0, 2, 51);
        t_align(1, 20, 10, 19, 1'b1, 1'b0, 0, 59);
        t_relative();
        report_and_stop();
    end
endmodule
`default_nettype wire
